// ---- pmsr_pkg.sv ----
package pmsr_pkg;

    localparam int PMSR_NUM_CH = 4;
    localparam int PMSR_ADDR_W = 8;
    localparam int PMSR_DATA_W = 32;
    localparam int PMSR_WORD_W = 24;
    localparam int PMSR_IRQ_W = 3;

    // byte offsets on the register bus
    localparam logic [7:0] PMSR_OFS_SELECT = 8'h00;
    localparam logic [7:0] PMSR_OFS_SYS_CTRL = 8'h04;
    localparam logic [7:0] PMSR_OFS_CHAN_RB = 8'h08;
    localparam logic [7:0] PMSR_OFS_COMP_RB = 8'h0C;
    localparam logic [7:0] PMSR_OFS_CHAN_CFG0 = 8'h10;
    localparam logic [7:0] PMSR_OFS_ALARM_RB = 8'h20;
    localparam logic [7:0] PMSR_OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] PMSR_OFS_IRQ_MASK = 8'h28;

    // field positions shared by write words and readback words
    localparam int PMSR_BIT_CLAMP = 9;
    localparam int PMSR_BIT_CMP_OE = 8;
    localparam int PMSR_BIT_CMP_VOLT = 7;
    localparam int PMSR_BIT_TEMP_CLR = 6;
    localparam int PMSR_BIT_TEMP_STICKY = 6;
    localparam int PMSR_BIT_TEMP_LIVE = 5;
    localparam int PMSR_BIT_MODE_HI = 23;
    localparam int PMSR_BIT_CMP_TOP = 21;
    localparam int PMSR_BIT_ALM_TEMP_STICKY = 21;
    localparam int PMSR_BIT_ALM_TEMP_LIVE = 20;
    localparam int PMSR_BIT_ALM_GUARD_TOP = 19;
    localparam int PMSR_BIT_ALM_CLAMP_TOP = 11;
    localparam int PMSR_IRQ_TEMP = 0;
    localparam int PMSR_IRQ_CLAMP = 1;
    localparam int PMSR_IRQ_GUARD = 2;

    // word type codes in bits 23:22
    localparam logic [1:0] PMSR_TYPE_CHAN = 2'h0;
    localparam logic [1:0] PMSR_TYPE_COMP = 2'h1;
    localparam logic [1:0] PMSR_TYPE_ALARM = 2'h3;

    // reset values
    localparam logic [1:0] PMSR_RST_SELECT = 2'h0;
    localparam logic [2:0] PMSR_RST_IRQ_MASK = 3'h0;
    localparam logic [31:0] PMSR_RST_RDATA = 32'h0000_0000;

    typedef struct packed {
        logic clamp_enable;
        logic cmp_out_enable;
        logic cmp_voltage;
    } pmsr_chan_s;

    typedef struct packed {
        logic temp_alarm;
        logic [PMSR_NUM_CH-1:0] clamp_alarm;
        logic [PMSR_NUM_CH-1:0] guard_alarm;
        logic [PMSR_NUM_CH-1:0] cmp_low;
        logic [PMSR_NUM_CH-1:0] cmp_high;
    } pmsr_pins_s;

    localparam int PMSR_PINS_W = $bits(pmsr_pins_s);

    typedef struct packed {
        logic [PMSR_ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [PMSR_DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } pmsr_avm_req_s;

    typedef struct packed {
        logic waitreq;
        logic [PMSR_DATA_W-1:0] rdata;
        logic [1:0] select;
        pmsr_chan_s [PMSR_NUM_CH-1:0] chan;
        logic temp_sticky;
        logic [PMSR_NUM_CH-1:0] clamp_latched;
        logic [PMSR_NUM_CH-1:0] guard_latched;
        logic temp_prev;
        logic clamp_any_prev;
        logic guard_any_prev;
        logic [PMSR_IRQ_W-1:0] irq_status;
        logic [PMSR_IRQ_W-1:0] irq_mask;
        logic irq;
    } pmsr_state_s;

endpackage

// ---- pmsr_sync.sv ----
`timescale 1ns/10ps
module pmsr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    // first stage feeds only the second stage
    logic [WIDTH-1:0] meta;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule

// ---- pmsr_status_readback.sv ----
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
// Function
// - channel word bit 9 returns the selected channel's clamp enable state.
// - clamp enable shows the last write, system-wide or per-channel.
// - channel word bit 8 returns the comparator output enable state.
// - comparator output enable shows the last write from either register.
// - channel word bit 7 is 1 for compare voltage, 0 for current.
// - bit 6 sticky over-temperature flag, bit 5 live over-temperature flag.
// - writing 1 to per-channel bit 6 clears the sticky temperature flag.
// - comparator status register is read-only; writes to it do nothing.
// - bits 21..14 hold low/high comparator pairs, channel 0 first.
// - read-only alarm status register reports temperature, clamp, guard alarms.
// - temperature flags appear in every per-channel readback word too.
// - channel word is 24 bits, type bits 00, one channel per readback.
module pmsr_status_readback
    import pmsr_pkg::*;
#(
    parameter int CH_COUNT = pmsr_pkg::PMSR_NUM_CH
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [pmsr_pkg::PMSR_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [pmsr_pkg::PMSR_DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [pmsr_pkg::PMSR_DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic temp_alarm_i,
    input wire logic [pmsr_pkg::PMSR_NUM_CH-1:0] clamp_alarm_i,
    input wire logic [pmsr_pkg::PMSR_NUM_CH-1:0] guard_alarm_i,
    input wire logic [pmsr_pkg::PMSR_NUM_CH-1:0] cmp_low_i,
    input wire logic [pmsr_pkg::PMSR_NUM_CH-1:0] cmp_high_i,
    output logic irq_o
);
    import pmsr_pkg::*;

    // comparator word layout has room for exactly four pairs
    if (CH_COUNT != PMSR_NUM_CH) begin : g_bad_count
        $error("pmsr_status_readback supports exactly four channels");
    end

    pmsr_state_s cur;
    pmsr_state_s nxt;
    pmsr_pins_s pins_raw;
    pmsr_pins_s pins;
    pmsr_avm_req_s req;

    assign pins_raw = '{temp_alarm: temp_alarm_i, clamp_alarm: clamp_alarm_i,
                        guard_alarm: guard_alarm_i, cmp_low: cmp_low_i,
                        cmp_high: cmp_high_i};
    assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i,
                   writedata: avs_writedata_i, byteenable: avs_byteenable_i};

    // all pin levels are asynchronous to the bus clock
    pmsr_sync #(
        .WIDTH(PMSR_PINS_W)
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .async_i(pins_raw),
        .sync_o(pins)
    );

    function automatic logic [PMSR_WORD_W-1:0] chan_word(input pmsr_chan_s ch,
                                                         input logic sticky,
                                                         input logic live);
        logic [PMSR_WORD_W-1:0] w;
        w = '0;
        w[PMSR_BIT_MODE_HI -: 2] = PMSR_TYPE_CHAN;
        w[PMSR_BIT_CLAMP] = ch.clamp_enable;
        w[PMSR_BIT_CMP_OE] = ch.cmp_out_enable;
        w[PMSR_BIT_CMP_VOLT] = ch.cmp_voltage;
        w[PMSR_BIT_TEMP_STICKY] = sticky;
        w[PMSR_BIT_TEMP_LIVE] = live;
        return w;
    endfunction

    function automatic logic [PMSR_WORD_W-1:0] comp_word(input pmsr_pins_s p);
        logic [PMSR_WORD_W-1:0] w;
        w = '0;
        w[PMSR_BIT_MODE_HI -: 2] = PMSR_TYPE_COMP;
        for (int i = 0; i < PMSR_NUM_CH; i++) begin
            w[PMSR_BIT_CMP_TOP - 2*i] = p.cmp_low[i];
            w[PMSR_BIT_CMP_TOP - 2*i - 1] = p.cmp_high[i];
        end
        return w;
    endfunction

    function automatic logic [PMSR_WORD_W-1:0] alarm_word(input pmsr_state_s s,
                                                          input pmsr_pins_s p);
        logic [PMSR_WORD_W-1:0] w;
        w = '0;
        w[PMSR_BIT_MODE_HI -: 2] = PMSR_TYPE_ALARM;
        w[PMSR_BIT_ALM_TEMP_STICKY] = s.temp_sticky;
        w[PMSR_BIT_ALM_TEMP_LIVE] = p.temp_alarm;
        for (int i = 0; i < PMSR_NUM_CH; i++) begin
            w[PMSR_BIT_ALM_GUARD_TOP - 2*i] = s.guard_latched[i];
            w[PMSR_BIT_ALM_GUARD_TOP - 2*i - 1] = p.guard_alarm[i];
            w[PMSR_BIT_ALM_CLAMP_TOP - 2*i] = s.clamp_latched[i];
            w[PMSR_BIT_ALM_CLAMP_TOP - 2*i - 1] = p.clamp_alarm[i];
        end
        return w;
    endfunction

    logic access;
    logic do_write;
    logic do_read;
    logic temp_clear;
    logic [PMSR_IRQ_W-1:0] irq_event;
    logic [PMSR_IRQ_W-1:0] irq_clear;
    logic [1:0] cfg_idx;
    logic cfg_hit;
    logic [PMSR_WORD_W-1:0] rd_word;

    always_comb begin
        nxt = cur;
        access = req.read | req.write;
        // bus side effects fire only at the edge that ends the ready cycle
        do_write = req.write & ~cur.waitreq;
        do_read = req.read & ~cur.waitreq;
        cfg_hit = (req.address >= PMSR_OFS_CHAN_CFG0) &&
                  (req.address < PMSR_OFS_ALARM_RB) && (req.address[1:0] == 2'h0);
        cfg_idx = req.address[3:2];
        temp_clear = 1'b0;
        irq_clear = '0;

        // one wait cycle per access, then a single ready cycle
        nxt.waitreq = ~(access & cur.waitreq);

        if (do_write) begin
            if (req.address == PMSR_OFS_SELECT && req.byteenable[0]) begin
                nxt.select = req.writedata[1:0];
            end
            if (req.address == PMSR_OFS_SYS_CTRL && req.byteenable[1]) begin
                for (int i = 0; i < PMSR_NUM_CH; i++) begin
                    nxt.chan[i].clamp_enable = req.writedata[PMSR_BIT_CLAMP];
                    nxt.chan[i].cmp_out_enable = req.writedata[PMSR_BIT_CMP_OE];
                end
            end
            if (cfg_hit) begin
                if (req.byteenable[1]) begin
                    nxt.chan[cfg_idx].clamp_enable = req.writedata[PMSR_BIT_CLAMP];
                    nxt.chan[cfg_idx].cmp_out_enable = req.writedata[PMSR_BIT_CMP_OE];
                end
                if (req.byteenable[0]) begin
                    nxt.chan[cfg_idx].cmp_voltage = req.writedata[PMSR_BIT_CMP_VOLT];
                    temp_clear = req.writedata[PMSR_BIT_TEMP_CLR];
                end
            end
            if (req.address == PMSR_OFS_IRQ_MASK && req.byteenable[0]) begin
                nxt.irq_mask = req.writedata[PMSR_IRQ_W-1:0];
            end
            // readback words, including comparator status, ignore writes
        end

        if (do_read && req.address == PMSR_OFS_IRQ_STAT) begin
            irq_clear = '1;
        end

        // latched alarms: a new alarm level wins over a same-cycle clear
        if (temp_clear) begin
            nxt.temp_sticky = 1'b0;
            nxt.clamp_latched = '0;
            nxt.guard_latched = '0;
        end
        if (pins.temp_alarm) begin
            nxt.temp_sticky = 1'b1;
        end
        nxt.clamp_latched = nxt.clamp_latched | pins.clamp_alarm;
        nxt.guard_latched = nxt.guard_latched | pins.guard_alarm;

        // events are rising edges of the synchronised alarm levels
        irq_event = '0;
        irq_event[PMSR_IRQ_TEMP] = pins.temp_alarm & ~cur.temp_prev;
        irq_event[PMSR_IRQ_CLAMP] = (|pins.clamp_alarm) & ~cur.clamp_any_prev;
        irq_event[PMSR_IRQ_GUARD] = (|pins.guard_alarm) & ~cur.guard_any_prev;
        nxt.temp_prev = pins.temp_alarm;
        nxt.clamp_any_prev = |pins.clamp_alarm;
        nxt.guard_any_prev = |pins.guard_alarm;
        nxt.irq_status = (cur.irq_status & ~irq_clear) | irq_event;
        nxt.irq = |(nxt.irq_status & nxt.irq_mask);

        // read data is captured during the wait cycle and held while ready
        rd_word = '0;
        case (req.address)
            PMSR_OFS_CHAN_RB: begin
                // only the selected channel is visible per readback
                rd_word = chan_word(cur.chan[cur.select], cur.temp_sticky,
                                    pins.temp_alarm);
            end
            PMSR_OFS_COMP_RB: begin
                rd_word = comp_word(pins);
            end
            PMSR_OFS_ALARM_RB: begin
                rd_word = alarm_word(cur, pins);
            end
            default: begin
                rd_word = '0;
            end
        endcase
        if (req.read && cur.waitreq) begin
            nxt.rdata = '0;
            case (req.address)
                PMSR_OFS_SELECT: nxt.rdata[1:0] = cur.select;
                PMSR_OFS_IRQ_STAT: nxt.rdata[PMSR_IRQ_W-1:0] = cur.irq_status;
                PMSR_OFS_IRQ_MASK: nxt.rdata[PMSR_IRQ_W-1:0] = cur.irq_mask;
                PMSR_OFS_CHAN_RB, PMSR_OFS_COMP_RB, PMSR_OFS_ALARM_RB: begin
                    nxt.rdata[PMSR_WORD_W-1:0] = rd_word;
                end
                default: nxt.rdata = PMSR_RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur <= '0;
            cur.waitreq <= 1'b1;
            cur.rdata <= PMSR_RST_RDATA;
            cur.select <= PMSR_RST_SELECT;
            cur.irq_mask <= PMSR_RST_IRQ_MASK;
        end else begin
            cur <= nxt;
        end
    end

    assign avs_readdata_o = cur.rdata;
    assign avs_waitrequest_o = cur.waitreq;
    assign irq_o = cur.irq;
endmodule

// ---- pmsr_chk.sv ----
`timescale 1ns/10ps
module pmsr_chk (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic temp_alarm_i,
    input wire logic [3:0] cmp_low_i,
    input wire logic [3:0] cmp_high_i
);
    import pmsr_pkg::*;
    logic [2:0] stb;
    logic rd_ok;
    logic [7:0] cmp_w;
    // pins pass a synchroniser, so only long-stable levels are compared
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            stb <= 3'h0;
        else
            stb <= !$stable({temp_alarm_i, cmp_low_i, cmp_high_i}) ? 3'h0 :
                (stb == 3'h7 ? stb : stb + 3'h1);
    end
    assign rd_ok = avs_read_i && !avs_waitrequest_o && stb > 3'h4;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cmp_w[7-2*i] = cmp_low_i[i];
            cmp_w[6-2*i] = cmp_high_i[i];
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("no ready after one wait cycle");
    AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("ready longer than one cycle");
    AST_IDLE_WAIT: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("ready without request");
    AST_CHAN_FMT: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i == PMSR_OFS_CHAN_RB |-> avs_readdata_o[31:22] == 10'h000 &&
        avs_readdata_o[4:0] == 5'h00) else $error("channel word frame wrong");
    AST_COMP_FMT: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i == PMSR_OFS_COMP_RB |-> avs_readdata_o[31:22] == 10'h001 &&
        avs_readdata_o[13:0] == 14'h0000) else $error("comparator word frame wrong");
    AST_COMP_BITS: assert property (rd_ok && avs_address_i == PMSR_OFS_COMP_RB
        |-> avs_readdata_o[21:14] == cmp_w) else $error("comparator bits wrong");
    AST_TEMP_LIVE: assert property (rd_ok && avs_address_i == PMSR_OFS_CHAN_RB
        |-> avs_readdata_o[5] == temp_alarm_i) else $error("live temp bit wrong");
    AST_TEMP_STICKY: assert property (rd_ok && avs_address_i == PMSR_OFS_CHAN_RB &&
        temp_alarm_i |-> avs_readdata_o[6]) else $error("sticky temp bit not set");
    AST_ALM_LIVE: assert property (rd_ok && avs_address_i == PMSR_OFS_ALARM_RB
        |-> avs_readdata_o[20] == temp_alarm_i) else $error("alarm word temp wrong");
endmodule
bind pmsr_status_readback pmsr_chk chk_u (.sys_clk_i, .resetn_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .temp_alarm_i,
    .cmp_low_i, .cmp_high_i);

// ---- pmsr_host.sv ----
`timescale 1ns/10ps
module pmsr_host (
    input wire logic sys_clk_i,
    input wire logic [31:0] rdata_i,
    input wire logic wait_i,
    output pmsr_pkg::pmsr_avm_req_s req_o
);
    import pmsr_pkg::*;
    logic [3:0] lane_en = 4'hf;
    initial req_o = '0;
    // one word per access; request held until ready is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge sys_clk_i);
        req_o <= '{address: a, read: !w, write: w, writedata: d, byteenable: lane_en};
        @(posedge sys_clk_i);
        while (wait_i !== 1'b0)
            @(posedge sys_clk_i);
        q = rdata_i;
        req_o.read <= 1'b0;
        req_o.write <= 1'b0;
    endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
    import pmsr_pkg::*;
    logic sys_clk_i = 0, resetn_i = 0, temp = 0, irq, wt;
    logic [3:0] cmp_lo = 0, cmp_hi = 0, clamp_al = 0, guard_al = 0;
    logic [31:0] rdata, q, exp_w, v;
    pmsr_avm_req_s req;
    int error_cnt = 0, total_checks = 0, cyc = 0, sel = 0, sticky = 0, ch;
    int clamp_m[4], cmp_oe_m[4], volt_m[4];
    pmsr_status_readback dut_u (.sys_clk_i, .resetn_i, .avs_address_i(req.address),
        .avs_read_i(req.read), .avs_write_i(req.write), .avs_writedata_i(req.writedata),
        .avs_byteenable_i(req.byteenable), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
        .temp_alarm_i(temp), .clamp_alarm_i(clamp_al), .guard_alarm_i(guard_al),
        .cmp_low_i(cmp_lo), .cmp_high_i(cmp_hi), .irq_o(irq));
    pmsr_host host_u (.sys_clk_i, .rdata_i(rdata), .wait_i(wt), .req_o(req));
    initial forever #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            $display("ERROR %0t timeout waiting for the test sequence", $time);
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        total_checks++;
        if (got !== e) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        host_u.xfer(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask
    // two sync edges plus margin
    task automatic settle();
        repeat (6) @(posedge sys_clk_i);
    endtask
    function automatic logic [31:0] chw();
        return 32'(clamp_m[sel] << 9 | cmp_oe_m[sel] << 8 | volt_m[sel] << 7 |
            sticky << 6 | temp << 5);
    endfunction
    task automatic set_sel(input int c);
        sel = c;
        wr(PMSR_OFS_SELECT, 32'(c));
    endtask
    initial begin
        void'($urandom(69645));
        repeat (5) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd(PMSR_OFS_CHAN_RB, 32'h0000_0000);
        rd(8'h3C, 32'h0000_0000);
        for (int i = 0; i < 30; i++) begin
            ch = $urandom_range(3);
            v = $urandom;
            case ($urandom_range(2))
                0: begin
                    wr(PMSR_OFS_SYS_CTRL, v);
                    foreach (clamp_m[k]) begin
                        clamp_m[k] = v[9];
                        cmp_oe_m[k] = v[8];
                    end
                end
                1: begin
                    wr(PMSR_OFS_CHAN_CFG0 + 8'(4 * ch), v & 32'h0000_0380);
                    clamp_m[ch] = v[9];
                    cmp_oe_m[ch] = v[8];
                    volt_m[ch] = v[7];
                end
                default: set_sel(ch);
            endcase
            rd(PMSR_OFS_CHAN_RB, chw());
        end
        rd(PMSR_OFS_SELECT, 32'(sel));
        // lane1 disabled: the system-wide enables must not move
        host_u.lane_en = 4'h1;
        wr(PMSR_OFS_SYS_CTRL, 32'h0000_0300);
        host_u.lane_en = 4'hf;
        rd(PMSR_OFS_CHAN_RB, chw());
        for (int i = 0; i < 6; i++) begin
            {cmp_lo, cmp_hi} <= 8'($urandom);
            settle();
            exp_w = 32'h0040_0000;
            for (int k = 0; k < 4; k++)
                exp_w[21-2*k -: 2] = {cmp_lo[k], cmp_hi[k]};
            rd(PMSR_OFS_COMP_RB, exp_w);
            wr(PMSR_OFS_COMP_RB, 32'hFFFF_FFFF);
            rd(PMSR_OFS_COMP_RB, exp_w);
        end
        wr(PMSR_OFS_IRQ_MASK, 32'h0000_0007);
        rd(PMSR_OFS_IRQ_MASK, 32'h0000_0007);
        temp <= 1'b1;
        settle();
        sticky = 1;
        chk(32'(irq), 32'h0000_0001);
        for (int k = 0; k < 4; k++) begin
            set_sel(k);
            rd(PMSR_OFS_CHAN_RB, chw());
        end
        rd(PMSR_OFS_ALARM_RB, 32'h00F0_0000);
        rd(PMSR_OFS_IRQ_STAT, 32'h0000_0001);
        settle();
        chk(32'(irq), 32'h0000_0000);
        // clear while still hot must not drop the flag
        wr(PMSR_OFS_CHAN_CFG0 + 8'(4 * sel), 32'h0000_0040);
        {clamp_m[sel], cmp_oe_m[sel], volt_m[sel]} = '0;
        rd(PMSR_OFS_CHAN_RB, chw());
        temp <= 1'b0;
        settle();
        rd(PMSR_OFS_CHAN_RB, chw());
        wr(PMSR_OFS_CHAN_CFG0 + 8'(4 * sel), 32'h0000_0040);
        sticky = 0;
        rd(PMSR_OFS_CHAN_RB, chw());
        wr(PMSR_OFS_IRQ_MASK, 32'h0000_0000);
        clamp_al <= 4'h1;
        guard_al <= 4'h2;
        settle();
        chk(32'(irq), 32'h0000_0000);
        rd(PMSR_OFS_ALARM_RB, 32'h00C3_0C00);
        rd(PMSR_OFS_IRQ_STAT, 32'h0000_0006);
        finish_test();
    end
endmodule
